// *** common/mstat_defines.vh ***
// Offsets, field positions, reset values and limits of the MAC statistics block
`ifndef MSTAT_DEFINES_VH
`define MSTAT_DEFINES_VH

// ==========================================
// Register map (byte addresses)
`define MSTAT_ADDR_W 8
`define MSTAT_CTRL_OFS 8'h00
`define MSTAT_MAXLEN_OFS 8'h04
`define MSTAT_STATUS_OFS 8'h08
`define MSTAT_CNT_BASE 8'h40
`define MSTAT_CNT_LIMIT 8'h80

// ==========================================
// Control fields and reset values
`define MSTAT_CTRL_CLR_BIT 0
`define MSTAT_CTRL_EN_BIT 1
`define MSTAT_CTRL_EN_RST 1'b1
`define MSTAT_MAXLEN_RST 16'h05ee

// ==========================================
// Counter indices, one 32-bit word each from the counter base
`define MSTAT_N_CNT 16
`define MSTAT_I_MULTI 0
`define MSTAT_I_EXCESS 1
`define MSTAT_I_LATE 2
`define MSTAT_I_STARVE 3
`define MSTAT_I_CARRIER 4
`define MSTAT_I_TXBYTES 5
`define MSTAT_I_BIN64 6
`define MSTAT_I_BIN_SMALL 7
`define MSTAT_I_BIN_MSMALL 8
`define MSTAT_I_BIN_MEDIUM 9
`define MSTAT_I_BIN_LARGE 10
`define MSTAT_I_BIN_LARGEST 11
`define MSTAT_I_NETBYTES 12
`define MSTAT_I_RX_START 13
`define MSTAT_I_RX_MIDDLE 14
`define MSTAT_I_RX_BUFFER 15

// ==========================================
// Collision and size limits
`define MSTAT_SLOT_BITS 512
`define MSTAT_LATE_BYTES 16'd64
`define MSTAT_MULTI_MIN 5'd2
`define MSTAT_LAST_RETRY 5'd15
`define MSTAT_MIN_FRAME 16'd64
`define MSTAT_SMALL_MAX 16'd127
`define MSTAT_MSMALL_MAX 16'd255
`define MSTAT_MEDIUM_MAX 16'd511
`define MSTAT_LARGE_MAX 16'd1023

`endif

// *** logic/mstat_cnt.v ***
// One statistics counter that adds a per-cycle increment
module mstat_cnt #(
   parameter W = 32,
   parameter IW = 17
) (
   input wire clk,
   input wire rst_n,
   input wire clr,
   input wire [IW-1:0] inc,
   output wire [W-1:0] cnt
);
   reg [W-1:0] cnt_r;
   wire [W-1:0] inc_ext;

   // ==========================================
   // Accumulator
   assign inc_ext = {{(W-IW){1'b0}}, inc};
   assign cnt = cnt_r;

   // Clear loads the increment, so an event in the clear cycle survives
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= {W{1'b0}};
      end else if (clr) begin
         cnt_r <= inc_ext;
      end else begin
         cnt_r <= cnt_r + inc_ext;
      end
   end
endmodule

// *** logic/mstat_size_bin.v ***
// Frame length to size-bin classifier, one-hot output
`include "mstat_defines.vh"
module mstat_size_bin (
   input wire [15:0] len,
   input wire [15:0] max_len,
   input wire hit,
   input wire hit64,
   output reg [5:0] bin
);
   // ==========================================
   // Range decode; the 64 bin has its own qualifier
   always @* begin
      bin = 6'h00;
      bin[0] = hit64 && (len == `MSTAT_MIN_FRAME);
      if (hit) begin
         bin[1] = (len > `MSTAT_MIN_FRAME) && (len <= `MSTAT_SMALL_MAX);
         bin[2] = (len > `MSTAT_SMALL_MAX) && (len <= `MSTAT_MSMALL_MAX);
         bin[3] = (len > `MSTAT_MSMALL_MAX) && (len <= `MSTAT_MEDIUM_MAX);
         bin[4] = (len > `MSTAT_MEDIUM_MAX) && (len <= `MSTAT_LARGE_MAX);
         bin[5] = (len > `MSTAT_LARGE_MAX) && (len <= max_len);
      end
   end
endmodule

// *** logic/mstat_top.v ***
// MAC transmit/receive statistics counters with a simple register port
`include "mstat_defines.vh"

// What this block does
// - Count frames sent after 2-15 collisions
// - Sixteenth collision abandons frame, counts excessive
// - Collision past 512 bits is late, abandons
// - Late frames also count as underrun, carrier loss if flagged
// - Multi/excessive need no carrier loss, underrun
// - Count frames whose FIFO ran empty
// - Count carrier loss frames, never retransmit
// - Add bytes of good transmitted frames
// - Count exact 64-byte frames, carrier-cut included
// - Bins 65-127, 128-255, 256-511 bytes
// - Bins 512-1023 and 1024 to maximum
// - Bins ignore CRC, code, overrun errors
// - Network bytes include every frame's bytes
// - Network bytes include aborted attempt bytes
// - Half-duplex receive bytes up to jam
// - Errors never stop network byte counting
// - Count matched frames overrun at start
// - Count matched frames overrun mid-frame
// - Count accepted frames lacking DMA head descriptor
// - Overruns counted for any length, any error
module mstat_top #(
   parameter CNT_W = 32,
   parameter LEN_W = 16
) (
   input wire clk,
   input wire rst_n,
   input wire [`MSTAT_ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_r,
   input wire tx_att_end,
   input wire [LEN_W-1:0] tx_att_bytes,
   input wire tx_att_coll,
   input wire tx_att_carrier_loss,
   input wire tx_att_starve,
   input wire rx_end,
   input wire [LEN_W-1:0] rx_len,
   input wire rx_match,
   input wire rx_jam_cut,
   input wire rx_start_ovr,
   input wire rx_middle_ovr,
   input wire rx_buffer_ovr,
   output reg tx_abandon_r,
   output reg tx_retry_r
);
   localparam IW = LEN_W + 1;
   localparam NC = `MSTAT_N_CNT;

   // ==========================================
   // Software-visible control
   reg count_en_r;
   reg [LEN_W-1:0] max_rx_frame_length_r;
   wire wr_ctrl;
   wire clr_all;

   // ==========================================
   // Per-frame transmit state
   reg [4:0] coll_cnt_r;
   reg [4:0] coll_cnt_nxt;
   reg starve_seen_r;
   reg starve_seen_nxt;

   // ==========================================
   // Decoded transmit outcome of this attempt
   reg late_coll;
   reg carrier_end;
   reg excessive;
   reg retry;
   reg success;
   reg starve_frame;
   reg frame_end;
   reg tx_hit;
   reg tx_hit64;

   // ==========================================
   // Receive qualifiers
   reg rx_hit;
   wire [5:0] tx_bin;
   wire [5:0] rx_bin;

   // ==========================================
   // Counter increments and values
   wire [NC*IW-1:0] inc_bus;
   wire [NC*CNT_W-1:0] cnt_bus;
   wire [IW-1:0] net_inc;
   wire [IW-1:0] tx_bytes_ext;
   wire [IW-1:0] rx_bytes_ext;
   wire [3:0] cnt_sel;
   wire cnt_hit;

   assign wr_ctrl = reg_wr && (reg_addr == `MSTAT_CTRL_OFS);
   assign clr_all = wr_ctrl && reg_wdata[`MSTAT_CTRL_CLR_BIT];

   // ==========================================
   // Control registers; clear bit is a write-only pulse
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_en_r <= `MSTAT_CTRL_EN_RST;
         max_rx_frame_length_r <= `MSTAT_MAXLEN_RST;
      end else begin
         if (wr_ctrl) begin
            count_en_r <= reg_wdata[`MSTAT_CTRL_EN_BIT];
         end
         if (reg_wr && (reg_addr == `MSTAT_MAXLEN_OFS)) begin
            max_rx_frame_length_r <= reg_wdata[LEN_W-1:0];
         end
      end
   end

   // ==========================================
   // Transmit attempt classification
   // Priority: late, then carrier loss, then ordinary collision, else sent.
   // Frame state advances even when counting is off, so a frame that
   // straddles re-enabling is still classified correctly.
   always @* begin
      late_coll = 1'b0;
      carrier_end = 1'b0;
      excessive = 1'b0;
      retry = 1'b0;
      success = 1'b0;
      starve_frame = starve_seen_r | tx_att_starve;
      coll_cnt_nxt = coll_cnt_r;
      starve_seen_nxt = starve_seen_r;
      if (tx_att_end) begin
         if (tx_att_coll && (tx_att_bytes > `MSTAT_LATE_BYTES)) begin
            late_coll = 1'b1;
         end else if (tx_att_carrier_loss) begin
            carrier_end = 1'b1;
         end else if (tx_att_coll) begin
            if (coll_cnt_r == `MSTAT_LAST_RETRY) begin
               excessive = 1'b1;
            end else begin
               retry = 1'b1;
            end
         end else begin
            success = 1'b1;
         end
         frame_end = late_coll | carrier_end | excessive | success;
         if (frame_end) begin
            coll_cnt_nxt = 5'h00;
            starve_seen_nxt = 1'b0;
         end else begin
            coll_cnt_nxt = coll_cnt_r + 5'h01;
            starve_seen_nxt = starve_frame;
         end
      end else begin
         frame_end = 1'b0;
      end
      // Bins exclude late, excessive, underrun; 64 bin keeps carrier-cut frames
      tx_hit = success && !starve_frame;
      tx_hit64 = (success || (carrier_end && !tx_att_coll)) && !starve_frame;
   end

   // ==========================================
   // Per-frame state and abandon/retry strobes to the transmitter
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coll_cnt_r <= 5'h00;
         starve_seen_r <= 1'b0;
         tx_abandon_r <= 1'b0;
         tx_retry_r <= 1'b0;
      end else begin
         coll_cnt_r <= coll_cnt_nxt;
         starve_seen_r <= starve_seen_nxt;
         tx_abandon_r <= late_coll | carrier_end | excessive;
         tx_retry_r <= retry;
      end
   end

   // ==========================================
   // Receive qualifiers; CRC and overrun never reach the bins
   always @* begin
      rx_hit = rx_end && !rx_jam_cut;
   end

   // ==========================================
   // Size classification for both directions
   mstat_size_bin u_tx_bin (
      .len(tx_att_bytes),
      .max_len(max_rx_frame_length_r),
      .hit(tx_hit),
      .hit64(tx_hit64),
      .bin(tx_bin)
   );

   mstat_size_bin u_rx_bin (
      .len(rx_len),
      .max_len(max_rx_frame_length_r),
      .hit(rx_hit),
      .hit64(rx_hit),
      .bin(rx_bin)
   );

   // ==========================================
   // Byte sums; jam-cut receive length already stops before the jam
   assign tx_bytes_ext = {1'b0, tx_att_bytes};
   assign rx_bytes_ext = {1'b0, rx_len};
   assign net_inc = (tx_att_end ? tx_bytes_ext : {IW{1'b0}})
      + (rx_end ? rx_bytes_ext : {IW{1'b0}});

   // ==========================================
   // Transmit collision and error increments
   assign inc_bus[`MSTAT_I_MULTI*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && success && !starve_frame
         && (coll_cnt_r >= `MSTAT_MULTI_MIN)};
   assign inc_bus[`MSTAT_I_EXCESS*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && excessive && !starve_frame};
   assign inc_bus[`MSTAT_I_LATE*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && late_coll};
   assign inc_bus[`MSTAT_I_STARVE*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && frame_end && starve_frame};
   assign inc_bus[`MSTAT_I_CARRIER*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && tx_att_end && tx_att_carrier_loss};
   assign inc_bus[`MSTAT_I_TXBYTES*IW +: IW] =
      (count_en_r && success && !starve_frame) ? tx_bytes_ext : {IW{1'b0}};

   // ==========================================
   // Shared bins: a transmit and a receive end may land in one cycle
   genvar b;
   generate
      for (b = 0; b < 6; b = b + 1) begin : g_bin
         assign inc_bus[(`MSTAT_I_BIN64+b)*IW +: IW] = count_en_r ?
            ({{(IW-1){1'b0}}, tx_bin[b]} + {{(IW-1){1'b0}}, rx_bin[b]}) :
            {IW{1'b0}};
      end
   endgenerate

   // ==========================================
   // Utilisation and receive overrun increments
   assign inc_bus[`MSTAT_I_NETBYTES*IW +: IW] =
      count_en_r ? net_inc : {IW{1'b0}};
   assign inc_bus[`MSTAT_I_RX_START*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && rx_end && rx_match && rx_start_ovr};
   assign inc_bus[`MSTAT_I_RX_MIDDLE*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && rx_end && rx_match
         && rx_middle_ovr && !rx_start_ovr};
   assign inc_bus[`MSTAT_I_RX_BUFFER*IW +: IW] =
      {{(IW-1){1'b0}}, count_en_r && rx_end && rx_match && rx_buffer_ovr};

   // ==========================================
   // Counter bank; each end pulse adds once, never held
   genvar c;
   generate
      for (c = 0; c < NC; c = c + 1) begin : g_cnt
         mstat_cnt #(
            .W(CNT_W),
            .IW(IW)
         ) u_cnt (
            .clk(clk),
            .rst_n(rst_n),
            .clr(clr_all),
            .inc(inc_bus[c*IW +: IW]),
            .cnt(cnt_bus[c*CNT_W +: CNT_W])
         );
      end
   endgenerate

   // ==========================================
   // Read decode; unmapped or misaligned addresses read zero
   assign cnt_hit = (reg_addr >= `MSTAT_CNT_BASE) && (reg_addr < `MSTAT_CNT_LIMIT)
      && (reg_addr[1:0] == 2'b00);
   assign cnt_sel = reg_addr[5:2];

   // Read data stands only in the cycle after the strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r <= 32'h00000000;
      end else if (reg_rd) begin
         if (reg_addr == `MSTAT_CTRL_OFS) begin
            reg_rdata_r <= {30'h0, count_en_r, 1'b0};
         end else if (reg_addr == `MSTAT_MAXLEN_OFS) begin
            reg_rdata_r <= {{(32-LEN_W){1'b0}}, max_rx_frame_length_r};
         end else if (reg_addr == `MSTAT_STATUS_OFS) begin
            reg_rdata_r <= {26'h0, starve_seen_r, coll_cnt_r};
         end else if (cnt_hit) begin
            reg_rdata_r <= cnt_bus[cnt_sel*CNT_W +: 32];
         end else begin
            reg_rdata_r <= 32'h00000000;
         end
      end else begin
         reg_rdata_r <= 32'h00000000;
      end
   end
endmodule

// *** dv/mstat_checker.sv ***
// Port assertions for the MAC statistics block
module mstat_checker #(
   parameter CNT_W = 32,
   parameter LEN_W = 16
) (
   input wire clk,
   input wire rst_n,
   input wire reg_rd,
   input wire [31:0] reg_rdata_r,
   input wire tx_att_end,
   input wire [LEN_W-1:0] tx_att_bytes,
   input wire tx_att_coll,
   input wire tx_att_carrier_loss,
   input wire tx_abandon_r,
   input wire tx_retry_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Retries seen in the current frame; cleared when the frame ends
   reg [4:0] coll_seen_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coll_seen_r <= 5'h0;
      end else if (tx_abandon_r || (tx_att_end && !tx_att_coll && !tx_att_carrier_loss)) begin
         coll_seen_r <= 5'h0;
      end else if (tx_retry_r) begin
         coll_seen_r <= coll_seen_r + 5'h1;
      end
   end
   // ==========================================
   // Attempt outcomes
   sequence s_late; tx_att_end && tx_att_coll && tx_att_bytes > 64; endsequence
   sequence s_early; tx_att_end && tx_att_coll && !tx_att_carrier_loss && tx_att_bytes <= 64; endsequence
   sequence s_good; tx_att_end && !tx_att_coll && !tx_att_carrier_loss; endsequence
   property p_late_abandon; s_late |=> tx_abandon_r && !tx_retry_r; endproperty
   property p_retry_limit; s_early ##0 (coll_seen_r < 5'd15) |=> tx_retry_r && !tx_abandon_r; endproperty
   property p_sixteenth; s_early ##0 (coll_seen_r == 5'd15) |=> tx_abandon_r && !tx_retry_r; endproperty
   property p_carrier_stop; tx_att_end && tx_att_carrier_loss |=> tx_abandon_r && !tx_retry_r; endproperty
   property p_good_quiet; s_good |=> !tx_abandon_r && !tx_retry_r; endproperty
   property p_idle_quiet; !tx_att_end |=> !tx_abandon_r && !tx_retry_r; endproperty
   property p_retry_cause; tx_retry_r |-> $past(tx_att_end && tx_att_coll); endproperty
   property p_abandon_cause; tx_abandon_r |-> $past(tx_att_end && (tx_att_coll || tx_att_carrier_loss)); endproperty
   property p_rd_idle; !reg_rd |=> reg_rdata_r == 32'h0; endproperty
   a_late_abandon: assert property (p_late_abandon) else $error("late collision not abandoned");
   a_retry_limit: assert property (p_retry_limit) else $error("early collision not retried");
   a_sixteenth: assert property (p_sixteenth) else $error("sixteenth collision not abandoned");
   a_carrier_stop: assert property (p_carrier_stop) else $error("carrier loss retried");
   a_good_quiet: assert property (p_good_quiet) else $error("good frame flagged");
   a_idle_quiet: assert property (p_idle_quiet) else $error("outcome without attempt");
   a_retry_cause: assert property (p_retry_cause) else $error("retry without collision");
   a_abandon_cause: assert property (p_abandon_cause) else $error("abandon without cause");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule

bind mstat_top mstat_checker #(.CNT_W(CNT_W), .LEN_W(LEN_W)) u_chk (
   .clk(clk),
   .rst_n(rst_n),
   .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r),
   .tx_att_end(tx_att_end),
   .tx_att_bytes(tx_att_bytes),
   .tx_att_coll(tx_att_coll),
   .tx_att_carrier_loss(tx_att_carrier_loss),
   .tx_abandon_r(tx_abandon_r),
   .tx_retry_r(tx_retry_r)
);

// *** dv/mstat_mac_model.sv ***
// MAC state machine stand-in that sends attempt and receive end pulses
module mstat_mac_model (
   input wire clk,
   output logic tx_att_end,
   output logic [15:0] tx_att_bytes,
   output logic [2:0] tx_flags,
   output logic rx_end,
   output logic [15:0] rx_len,
   output logic [4:0] rx_flags
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {tx_att_end, tx_att_bytes, tx_flags} = '0;
      {rx_end, rx_len, rx_flags} = '0;
   end
   // ==========================================
   // One-cycle pulses; qualifiers scrambled once released so stale values never help
   task automatic tx(input [15:0] b, input [2:0] f);
      @(posedge clk);
      {tx_att_end, tx_att_bytes, tx_flags} <= {1'b1, b, f};
      @(posedge clk);
      {tx_att_end, tx_att_bytes, tx_flags} <= {1'b0, ~b, ~f};
   endtask
   task automatic rx(input [15:0] l, input [4:0] f);
      @(posedge clk);
      {rx_end, rx_len, rx_flags} <= {1'b1, l, f};
      @(posedge clk);
      {rx_end, rx_len, rx_flags} <= {1'b0, ~l, ~f};
   endtask
endmodule

// *** dv/tb_mstat_top.sv ***
// Self-checking bench for the MAC statistics block
`include "mstat_defines.vh"
module tb_mstat_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, reg_wr, reg_rd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   wire [31:0] reg_rdata_r;
   wire tx_att_end, rx_end, tx_abandon_r, tx_retry_r;
   wire [15:0] tx_att_bytes, rx_len;
   wire [2:0] txf;
   wire [4:0] rxf;
   logic [31:0] ex [16];
   int err_total, samples_checked;
   int lens [13] = '{64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519, 30};
   mstat_mac_model mdl (.clk(clk), .tx_att_end(tx_att_end), .tx_att_bytes(tx_att_bytes), .tx_flags(txf),
      .rx_end(rx_end), .rx_len(rx_len), .rx_flags(rxf));
   mstat_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .tx_att_end(tx_att_end), .tx_att_bytes(tx_att_bytes),
      .tx_att_coll(txf[2]), .tx_att_carrier_loss(txf[1]), .tx_att_starve(txf[0]), .rx_end(rx_end),
      .rx_len(rx_len), .rx_match(rxf[4]), .rx_jam_cut(rxf[3]), .rx_start_ovr(rxf[2]),
      .rx_middle_ovr(rxf[1]), .rx_buffer_ovr(rxf[0]), .tx_abandon_r(tx_abandon_r), .tx_retry_r(tx_retry_r));
   // ==========================================
   // Register port tasks
   task automatic wr(input [7:0] a, input [31:0] d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, input [31:0] e);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      samples_checked++;
      if (reg_rdata_r !== e) begin
         err_total++;
         $display("wrong value at %h expected %h seen %h", a, e, reg_rdata_r);
      end
   endtask
   task automatic chk_all;
      for (int i = 0; i < 16; i++) rd(`MSTAT_CNT_BASE + 8'(4 * i), ex[i]);
   endtask
   // ==========================================
   // Expectation helpers; bin limits follow the reset maximum length
   function automatic int bin_of(input int l);
      return l < 64 ? -1 : l == 64 ? 6 : l < 128 ? 7 : l < 256 ? 8 : l < 512 ? 9 : l < 1024 ? 10 : l <= 1518 ? 11 : -1;
   endfunction
   task automatic binup(input int l);
      if (bin_of(l) >= 0) ex[bin_of(l)]++;
   endtask
   task automatic coll(input int n, input [15:0] b);
      repeat (n) mdl.tx(b, 3'b100);
      ex[12] += n * b;
   endtask
   task automatic good(input [15:0] b);
      mdl.tx(b, 3'b000);
      ex[5] += b;
      ex[12] += b;
      binup(b);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim;
   end
   // ==========================================
   // Main sequence
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      ex = '{default: 32'h0};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(`MSTAT_CTRL_OFS, 32'h2);
      rd(`MSTAT_MAXLEN_OFS, 32'h5ee);
      rd(8'h20, 32'h0);
      wr(`MSTAT_CNT_BASE, 32'h5);
      coll(1, 30); good(200);
      coll(2, 20); good(100); ex[0]++;
      coll(15, 10); good(64); ex[0]++;
      coll(16, 10); ex[1]++;
      coll(15, 10); mdl.tx(70, 3'b100); ex[2]++; ex[12] += 70;
      coll(2, 10); mdl.tx(64, 3'b001); ex[3]++; ex[12] += 64;
      coll(2, 10); mdl.tx(64, 3'b010); ex[4]++; ex[6]++; ex[12] += 64;
      mdl.tx(80, 3'b111); ex[2]++; ex[3]++; ex[4]++; ex[12] += 80;
      chk_all;
      for (int i = 0; i < 13; i++) begin
         mdl.rx(lens[i], {i[0], 4'h0});
         binup(lens[i]);
         ex[12] += lens[i];
      end
      mdl.rx(40, 5'b11000); ex[12] += 40;
      mdl.rx(30, 5'b10100); ex[13]++; ex[12] += 30;
      mdl.rx(300, 5'b10010); ex[14]++; ex[9]++; ex[12] += 300;
      mdl.rx(2000, 5'b10011); ex[14]++; ex[15]++; ex[12] += 2000;
      chk_all;
      wr(`MSTAT_CTRL_OFS, 32'h0);
      good(100);
      ex[5] -= 100; ex[7]--; ex[12] -= 100;
      chk_all;
      wr(`MSTAT_CTRL_OFS, 32'h3);
      ex = '{default: 32'h0};
      chk_all;
      good(65);
      chk_all;
      // Raised maximum length moves 1519 into the top bin
      wr(`MSTAT_MAXLEN_OFS, 32'h5ef);
      rd(`MSTAT_MAXLEN_OFS, 32'h5ef);
      mdl.rx(1519, 5'b10000); ex[11]++; ex[12] += 1519;
      // Collision state is visible in status while a frame is pending
      coll(3, 10);
      rd(`MSTAT_STATUS_OFS, 32'h3);
      chk_all;
      end_sim;
   end
endmodule
